// File: design/lfc_unit.sv
// lock bits, fuse bytes, signature row and calibration with apb access
`timescale 1ns/1ns
`default_nettype none
module lfc_unit #(
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'h42, // arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'h17, // arbitrary value
	parameter logic [7:0] CAL_1MHZ  = 8'h80, // plain default
	parameter logic [7:0] CAL_2MHZ  = 8'h81, // plain default
	parameter logic [7:0] CAL_4MHZ  = 8'h82, // plain default
	parameter logic [7:0] CAL_8MHZ  = 8'h83  // plain default
) (
	input  wire logic        clk,               // core clock
	input  wire logic        srst,              // sync reset, high
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb enable
	input  wire logic        pwrite,            // apb direction
	input  wire logic [11:0] paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic             pready,            // apb ready
	output logic [31:0]      prdata,            // apb read data
	output logic             pslverr,           // apb error
	input  wire logic        prog_mode,         // programming mode active
	input  wire logic        prog_serial,       // 1 serial, 0 parallel path
	input  wire logic        prog_cmd_valid,    // command strobe
	input  wire logic [7:0]  prog_cmd,          // command byte
	input  wire logic [1:0]  prog_sel,          // byte select / row address
	input  wire logic        prog_cal,          // signature row high byte
	input  wire logic [7:0]  prog_wdata,        // fuse or lock data
	output logic             prog_ack,          // command done
	output logic             prog_refused,      // command refused
	output logic [7:0]       prog_rdata,        // read result
	output logic             prog_busy,         // chip erase running
	output logic             flash_erase_req,   // flash erase request
	input  wire logic        flash_erase_done,  // flash erase finished
	output logic             eeprom_erase,      // eeprom erase pulse
	input  wire logic        spm_req,           // self-programming store
	input  wire logic [11:0] spm_addr,          // store word address
	input  wire logic [11:0] lpm_addr,          // program read address
	input  wire logic        pc_in_boot,        // executing in boot section
	input  wire logic        vectors_in_boot,   // vectors in boot section
	output logic             spm_allow,         // store permitted
	output logic             lpm_allow,         // program read permitted
	output logic             irq_block,         // interrupts disabled
	output logic [7:0]       fuse_high_cfg,     // latched fuse high byte
	output logic [7:0]       fuse_low_cfg,      // latched fuse low byte
	output logic [7:0]       lock_cfg,          // lock byte
	output logic             eeprom_preserve,   // live preserve fuse, high=on
	output logic [7:0]       osc_calibration    // oscillator trim
);
	logic [7:0]  lock_reg, lock_next;
	logic [7:0]  fuse_hi_reg, fuse_hi_next;
	logic [7:0]  fuse_lo_reg, fuse_lo_next;
	logic [7:0]  fuse_hi_lat_reg, fuse_lo_lat_reg;
	logic        power_up_reg, prog_mode_d_reg;
	logic [7:0]  osc_calibration_reg;
	logic        ee_keep_reg;
	lfc_pkg::lfc_ce_state_t ce_state_reg, ce_state_next;
	logic        pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic        ack_reg, refused_reg, erase_req_reg, ee_erase_reg;
	logic [7:0]  prog_rdata_reg;
	logic        spm_allow_reg, lpm_allow_reg, irq_block_reg;

	// fuse latch events
	wire latch_now = power_up_reg | (prog_mode ^ prog_mode_d_reg);

	// lock pairs
	wire [1:0] mem_pair  = {lock_reg[lfc_pkg::MEM_LOCK_HI], lock_reg[lfc_pkg::MEM_LOCK_LO]};
	wire       mem_wr_lk = (mem_pair != lfc_pkg::PAIR_OPEN);
	wire       mem_rd_lk = (mem_pair == lfc_pkg::PAIR_CLOSED);
	wire       app_no_wr = ~lock_reg[lfc_pkg::APP_LOCK_LO];
	wire       app_no_rd = ~lock_reg[lfc_pkg::APP_LOCK_HI];
	wire       boot_no_wr = ~lock_reg[lfc_pkg::BOOT_LOCK_LO];
	wire       boot_no_rd = ~lock_reg[lfc_pkg::BOOT_LOCK_HI];

	// programmer access checks, uses stored fuses since they protect at once
	wire rst_pin_off = ~fuse_hi_reg[lfc_pkg::RESET_PIN_DISABLE];
	wire ser_off     = fuse_hi_reg[lfc_pkg::SERIAL_PROG_EN];
	wire ser_blocked = prog_serial & (rst_pin_off | ser_off);
	wire cmd_take    = prog_cmd_valid & prog_mode;
	wire ce_idle     = (ce_state_reg == lfc_pkg::LFC_CE_IDLE);
	logic cmd_refuse;
	always_comb
	begin
		case (prog_cmd)
			lfc_pkg::CMD_CHIP_ERASE: cmd_refuse = ser_blocked;
			lfc_pkg::CMD_WR_FUSE:    cmd_refuse = ser_blocked | mem_wr_lk;
			lfc_pkg::CMD_WR_LOCK:    cmd_refuse = ser_blocked;
			lfc_pkg::CMD_WR_FLASH:   cmd_refuse = ser_blocked | mem_wr_lk;
			lfc_pkg::CMD_WR_EEPROM:  cmd_refuse = ser_blocked | mem_wr_lk;
			lfc_pkg::CMD_RD_SIG:     cmd_refuse = 1'b0;
			lfc_pkg::CMD_RD_FUSE:    cmd_refuse = ser_blocked;
			lfc_pkg::CMD_RD_FLASH:   cmd_refuse = ser_blocked | mem_rd_lk;
			lfc_pkg::CMD_RD_EEPROM:  cmd_refuse = ser_blocked | mem_rd_lk;
			default:                 cmd_refuse = 1'b1;
		endcase
	end
	// a command during erase is refused; the programmer must wait for busy low
	wire cmd_ok  = cmd_take & ce_idle & ~cmd_refuse;
	wire cmd_bad = cmd_take & ~(ce_idle & ~cmd_refuse);
	wire do_erase = cmd_ok & (prog_cmd == lfc_pkg::CMD_CHIP_ERASE);
	wire do_fuse  = cmd_ok & (prog_cmd == lfc_pkg::CMD_WR_FUSE);
	wire do_lock  = cmd_ok & (prog_cmd == lfc_pkg::CMD_WR_LOCK);
	wire erase_end = ~ce_idle & flash_erase_done;

	// serial writes keep the serial enable fuse as it is
	wire [7:0] hi_keep_mask = 8'(prog_serial) << lfc_pkg::SERIAL_PROG_EN;
	wire [7:0] hi_write = (prog_wdata & ~hi_keep_mask) | (fuse_hi_reg & hi_keep_mask);

	// read data
	wire [7:0] sig_byte = (prog_sel == 2'h0) ? SIG_BYTE0 :
	                      (prog_sel == 2'h1) ? SIG_BYTE1 :
	                      (prog_sel == lfc_pkg::SIG_LAST) ? SIG_BYTE2 : 8'hff;
	wire [7:0] cal_byte = (prog_sel == 2'h0) ? CAL_1MHZ :
	                      (prog_sel == 2'h1) ? CAL_2MHZ :
	                      (prog_sel == 2'h2) ? CAL_4MHZ : CAL_8MHZ;
	wire [7:0] fuse_rd  = (prog_sel == lfc_pkg::SEL_LOW)  ? fuse_lo_reg :
	                      (prog_sel == lfc_pkg::SEL_HIGH) ? (fuse_hi_reg | hi_keep_mask) :
	                      (prog_sel == lfc_pkg::SEL_LOCK) ? lock_reg : 8'hff;
	wire [7:0] prog_rd  = (prog_cmd == lfc_pkg::CMD_RD_SIG) ? (prog_cal ? cal_byte : sig_byte) :
	                      (prog_cmd == lfc_pkg::CMD_RD_FUSE) ? fuse_rd : 8'h00;

	// apb decode: one wait state, answer registered in the second access cycle
	wire apb_acc   = psel & penable & ~pready_reg;
	wire apb_done  = psel & penable & pready_reg;
	wire hit_lock  = (paddr == lfc_pkg::OFS_LOCK);
	wire hit_fuse  = (paddr == lfc_pkg::OFS_FUSE);
	wire hit_osc   = (paddr == lfc_pkg::OFS_OSC_CALIBRATION_REG);
	wire hit_stat  = (paddr == lfc_pkg::OFS_STATUS);
	wire hit_cal   = (paddr[11:4] == lfc_pkg::CAL_PAGE) & (paddr[1:0] == 2'h0);
	wire apb_hit   = hit_lock | hit_fuse | hit_osc | hit_stat | hit_cal;
	wire [7:0] apb_cal = (paddr[3:2] == 2'h0) ? CAL_1MHZ :
	                     (paddr[3:2] == 2'h1) ? CAL_2MHZ :
	                     (paddr[3:2] == 2'h2) ? CAL_4MHZ : CAL_8MHZ;
	wire [31:0] apb_rd = hit_lock ? {24'h000000, lock_reg} :
	                     hit_fuse ? {16'h0000, fuse_hi_lat_reg, fuse_lo_lat_reg} :
	                     hit_osc  ? {24'h000000, osc_calibration_reg} :
	                     hit_stat ? {30'h0, prog_mode, ~ce_idle} :
	                     hit_cal  ? {24'h000000, apb_cal} : 32'h00000000;
	// a software lock store goes through the same clear-only path
	wire apb_lock_wr = apb_done & pwrite & hit_lock;

	// lock byte next value
	always_comb
	begin
		lock_next = lock_reg;
		if (erase_end)
			lock_next = lfc_pkg::LOCK_DEFAULT;
		else if (do_lock)
			lock_next = lock_reg & (prog_wdata | lfc_pkg::LOCK_UNUSED);
		else if (apb_lock_wr)
			lock_next = lock_reg & (pwdata[7:0] | lfc_pkg::LOCK_UNUSED);
	end

	// fuse bytes: chip erase never touches them
	assign fuse_hi_next = (do_fuse & (prog_sel == lfc_pkg::SEL_HIGH)) ? hi_write : fuse_hi_reg;
	assign fuse_lo_next = (do_fuse & (prog_sel == lfc_pkg::SEL_LOW)) ? prog_wdata : fuse_lo_reg;

	// erase sequencer
	always_comb
	begin
		case (ce_state_reg)
			lfc_pkg::LFC_CE_IDLE:  ce_state_next = do_erase ? lfc_pkg::LFC_CE_ERASE : ce_state_reg;
			lfc_pkg::LFC_CE_ERASE: ce_state_next = flash_erase_done ? lfc_pkg::LFC_CE_IDLE : ce_state_reg;
			default:               ce_state_next = lfc_pkg::LFC_CE_IDLE;
		endcase
	end

	// boot section boundary from latched boot size
	wire [1:0]  boot_sz = fuse_hi_lat_reg[lfc_pkg::BOOT_SIZE_HI:lfc_pkg::BOOT_SIZE_LO];
	wire [11:0] boot_start = (boot_sz == 2'h3) ? lfc_pkg::BOOT_START_3 :
	                         (boot_sz == 2'h2) ? lfc_pkg::BOOT_START_2 :
	                         (boot_sz == 2'h1) ? lfc_pkg::BOOT_START_1 : lfc_pkg::BOOT_START_0;
	wire spm_in_boot = (spm_addr >= boot_start);
	wire lpm_in_boot = (lpm_addr >= boot_start);
	wire spm_ok = spm_in_boot ? ~boot_no_wr : ~app_no_wr;
	wire lpm_ok = (pc_in_boot == lpm_in_boot) ? 1'b1 :
	              (pc_in_boot ? ~app_no_rd : ~boot_no_rd);
	wire irq_off = (app_no_rd & vectors_in_boot & ~pc_in_boot) |
	               (boot_no_rd & ~vectors_in_boot & pc_in_boot);

	// nonvolatile state; srst stands for power-up here
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			lock_reg    <= lfc_pkg::LOCK_DEFAULT;
			fuse_hi_reg <= lfc_pkg::FUSE_HI_DEFAULT;
			fuse_lo_reg <= lfc_pkg::FUSE_LO_DEFAULT;
			ee_keep_reg <= ~lfc_pkg::FUSE_HI_DEFAULT[lfc_pkg::EEPROM_PRESERVE];
		end
		else
		begin
			lock_reg    <= lock_next;
			fuse_hi_reg <= fuse_hi_next;
			fuse_lo_reg <= fuse_lo_next;
			ee_keep_reg <= ~fuse_hi_next[lfc_pkg::EEPROM_PRESERVE];
		end
	end

	// latched fuses only move on a latch event
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fuse_hi_lat_reg <= lfc_pkg::FUSE_HI_DEFAULT;
			fuse_lo_lat_reg <= lfc_pkg::FUSE_LO_DEFAULT;
			power_up_reg    <= 1'b1;
			prog_mode_d_reg <= 1'b0;
		end
		else
		begin
			if (latch_now)
			begin
				fuse_hi_lat_reg <= fuse_hi_reg;
				fuse_lo_lat_reg <= fuse_lo_reg;
			end
			power_up_reg    <= 1'b0;
			prog_mode_d_reg <= prog_mode;
		end
	end

	// programmer answers and erase control
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ce_state_reg   <= lfc_pkg::LFC_CE_IDLE;
			ack_reg        <= 1'b0;
			refused_reg    <= 1'b0;
			erase_req_reg  <= 1'b0;
			ee_erase_reg   <= 1'b0;
			prog_rdata_reg <= 8'h00;
		end
		else
		begin
			ce_state_reg   <= ce_state_next;
			ack_reg        <= (cmd_ok & ~do_erase) | erase_end;
			refused_reg    <= cmd_bad;
			erase_req_reg  <= do_erase | (erase_req_reg & ~flash_erase_done);
			ee_erase_reg   <= do_erase & fuse_hi_reg[lfc_pkg::EEPROM_PRESERVE];
			prog_rdata_reg <= cmd_ok ? prog_rd : prog_rdata_reg;
		end
	end

	// core access checks and oscillator trim
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			spm_allow_reg       <= 1'b1;
			lpm_allow_reg       <= 1'b1;
			irq_block_reg       <= 1'b0;
			osc_calibration_reg <= CAL_1MHZ;
		end
		else
		begin
			spm_allow_reg <= spm_ok;
			lpm_allow_reg <= lpm_ok;
			irq_block_reg <= irq_off;
			if (apb_done & pwrite & hit_osc)
				osc_calibration_reg <= pwdata[7:0];
		end
	end

	// apb answer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end
		else
		begin
			pready_reg  <= apb_acc;
			pslverr_reg <= apb_acc & ~apb_hit;
			prdata_reg  <= (apb_acc & ~pwrite) ? apb_rd : 32'h00000000;
		end
	end

	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign prdata          = prdata_reg;
	assign prog_ack        = ack_reg;
	assign prog_refused    = refused_reg;
	assign prog_rdata      = prog_rdata_reg;
	assign prog_busy       = erase_req_reg;
	assign flash_erase_req = erase_req_reg;
	assign eeprom_erase    = ee_erase_reg;
	assign spm_allow       = spm_allow_reg;
	assign lpm_allow       = lpm_allow_reg;
	assign irq_block       = irq_block_reg;
	// static configuration for clock, reset, watchdog, brown-out, boot logic
	assign fuse_high_cfg   = fuse_hi_lat_reg;
	assign fuse_low_cfg    = fuse_lo_lat_reg;
	assign lock_cfg        = lock_reg;
	// preserve is not latched so an erase right after programming it is safe
	assign eeprom_preserve = ee_keep_reg;
	assign osc_calibration = osc_calibration_reg;

	lock_one_way_a: assert property (@(posedge clk) disable iff (srst)
		!$past(erase_end) |-> ((lock_reg & ~$past(lock_reg)) == 8'h00))
		else $error("lock bit returned to 1 outside chip erase");
	lock_unused_a: assert property (@(posedge clk) disable iff (srst)
		lock_reg[7:6] == 2'h3)
		else $error("unused lock bits not 1");
	erase_lock_a: assert property (@(posedge clk) disable iff (srst)
		(ce_state_reg == lfc_pkg::LFC_CE_ERASE && !flash_erase_done)
		|=> ((lock_reg & ~$past(lock_reg)) == 8'h00) && prog_busy)
		else $error("lock bits released before flash erase done");
	fuse_erase_a: assert property (@(posedge clk) disable iff (srst)
		do_erase |=> $stable(fuse_hi_reg) && $stable(fuse_lo_reg))
		else $error("chip erase changed a fuse");
	fuse_locked_a: assert property (@(posedge clk) disable iff (srst)
		(cmd_take && prog_cmd == lfc_pkg::CMD_WR_FUSE && mem_wr_lk)
		|=> prog_refused && $stable(fuse_hi_reg) && $stable(fuse_lo_reg))
		else $error("fuse write accepted under memory lock");
	latch_hold_a: assert property (@(posedge clk) disable iff (srst)
		(prog_mode && $past(prog_mode) && !$past(power_up_reg)) |-> $stable(fuse_high_cfg))
		else $error("latched fuse moved inside programming mode");
	store_deny_a: assert property (@(posedge clk) disable iff (srst)
		(spm_req && spm_in_boot && !lock_reg[lfc_pkg::BOOT_LOCK_LO]) |=> !spm_allow)
		else $error("store into locked boot section allowed");
	read_deny_a: assert property (@(posedge clk) disable iff (srst)
		(pc_in_boot && !lpm_in_boot && !lock_reg[lfc_pkg::APP_LOCK_HI]) |=> !lpm_allow)
		else $error("boot read of locked application allowed");
	irq_off_a: assert property (@(posedge clk) disable iff (srst)
		(pc_in_boot && !vectors_in_boot && !lock_reg[lfc_pkg::BOOT_LOCK_HI]) |=> irq_block)
		else $error("interrupts not blocked in locked boot section");
	serial_keep_a: assert property (@(posedge clk) disable iff (srst)
		(cmd_take && prog_serial) |=> $stable(fuse_hi_reg[lfc_pkg::SERIAL_PROG_EN]))
		else $error("serial path altered serial enable fuse");
	osc_reset_a: assert property (@(posedge clk)
		srst |=> osc_calibration == CAL_1MHZ)
		else $error("calibration not loaded at reset");
	apb_wait_a: assert property (@(posedge clk) disable iff (srst)
		(psel && !penable) ##1 (psel && penable) |=> pready)
		else $error("apb answer not after one wait state");

	erase_cov: cover property (@(posedge clk) disable iff (srst) do_erase ##[1:50] erase_end);
	fuse_wr_cov: cover property (@(posedge clk) disable iff (srst) do_fuse ##[1:20] !prog_mode);
	sig_cov: cover property (@(posedge clk) disable iff (srst)
		cmd_ok && prog_cmd == lfc_pkg::CMD_RD_SIG && mem_rd_lk);
	deny_cov: cover property (@(posedge clk) disable iff (srst) spm_req ##1 !spm_allow);
endmodule
`default_nettype wire

// File: design/lfc_pkg.sv
// constants shared by the lock, fuse and configuration unit
`default_nettype none
package lfc_pkg;
	// lock byte layout and reset value
	localparam logic [7:0] LOCK_DEFAULT  = 8'hff;
	localparam logic [7:0] LOCK_UNUSED   = 8'hc0;
	localparam int         MEM_LOCK_LO   = 0;
	localparam int         MEM_LOCK_HI   = 1;
	localparam int         APP_LOCK_LO   = 2;
	localparam int         APP_LOCK_HI   = 3;
	localparam int         BOOT_LOCK_LO  = 4;
	localparam int         BOOT_LOCK_HI  = 5;
	localparam logic [1:0] PAIR_OPEN     = 2'h3;
	localparam logic [1:0] PAIR_CLOSED   = 2'h0;
	// fuse high byte layout
	localparam logic [7:0] FUSE_HI_DEFAULT   = 8'hd9;
	localparam int         RESET_PIN_DISABLE = 7;
	localparam int         WATCHDOG_ON       = 6;
	localparam int         SERIAL_PROG_EN    = 5;
	localparam int         OSC_OPTION        = 4;
	localparam int         EEPROM_PRESERVE   = 3;
	localparam int         BOOT_SIZE_HI      = 2;
	localparam int         BOOT_SIZE_LO      = 1;
	localparam int         RESET_VECTOR_SEL  = 0;
	// fuse low byte layout
	localparam logic [7:0] FUSE_LO_DEFAULT   = 8'he1;
	localparam int         BROWNOUT_LEVEL    = 7;
	localparam int         BROWNOUT_ENABLE   = 6;
	localparam int         STARTUP_HI        = 5;
	localparam int         STARTUP_LO        = 4;
	localparam int         CLOCK_SRC_HI      = 3;
	localparam int         CLOCK_SRC_LO      = 0;
	// boot section start word address per boot size code
	localparam logic [11:0] BOOT_START_3 = 12'hf80;
	localparam logic [11:0] BOOT_START_2 = 12'hf00;
	localparam logic [11:0] BOOT_START_1 = 12'he00;
	localparam logic [11:0] BOOT_START_0 = 12'hc00;
	// programmer command bytes
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
	localparam logic [7:0] CMD_RD_SIG     = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;
	// byte select for fuse and lock access
	localparam logic [1:0] SEL_LOW  = 2'h0;
	localparam logic [1:0] SEL_HIGH = 2'h1;
	localparam logic [1:0] SEL_LOCK = 2'h2;
	localparam logic [1:0] SIG_LAST = 2'h2;
	// apb register byte offsets
	localparam logic [11:0] OFS_LOCK   = 12'h000;
	localparam logic [11:0] OFS_FUSE   = 12'h004;
	localparam logic [11:0] OFS_OSC_CALIBRATION_REG = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [7:0]  CAL_PAGE   = 8'h01;
	typedef enum logic {LFC_CE_IDLE, LFC_CE_ERASE} lfc_ce_state_t;
endpackage
`default_nettype wire

// File: bench/lfc_flash_model.sv
// stand-in for the flash erase machinery behind the lock and fuse unit
`timescale 1ns/1ns
`default_nettype none
module lfc_flash_model (
	input  wire logic clk,              // core clock
	input  wire logic srst,             // sync reset, high
	input  wire logic slow,             // long erase when high
	input  wire logic flash_erase_req,  // erase request
	output logic      flash_erase_done  // erase finished
);
	int cnt;
	// done only once the whole array is wiped, never ahead of it
	assign flash_erase_done = flash_erase_req && (cnt == (slow ? 40 : 2));
	always_ff @(posedge clk)
	begin
		if (srst || !flash_erase_req)
			cnt <= 0;
		else
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the lock, fuse and calibration unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module tb;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, slow;
	logic [11:0] paddr, spm_addr, lpm_addr;
	logic [31:0] pwdata, prdata;
	logic        prog_mode, prog_serial, prog_cmd_valid, prog_cal, prog_ack, prog_refused;
	logic [7:0]  prog_cmd, prog_wdata, prog_rdata, fuse_high_cfg, fuse_low_cfg, lock_cfg;
	logic [1:0]  prog_sel;
	logic        prog_busy, flash_erase_req, flash_erase_done, eeprom_erase, spm_req;
	logic        pc_in_boot, vectors_in_boot, spm_allow, lpm_allow, irq_block;
	logic        eeprom_preserve;
	logic [7:0]  osc_calibration, lk, d;
	logic [11:0] sa, la, st;
	logic [7:0]  sig_e [4] = '{8'h5a, 8'h42, 8'h17, 8'hff};
	logic [7:0]  cal_e [4] = '{8'h6c, 8'h81, 8'h82, 8'h83};
	logic [11:0] bs_e [4]  = '{12'hc00, 12'he00, 12'hf00, 12'hf80};
	int          bad_count, n_tests, ee_n, seed, k, r;
	lfc_unit #(.CAL_1MHZ(8'h6c)) dut (
		.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.prog_mode(prog_mode), .prog_serial(prog_serial), .prog_cmd_valid(prog_cmd_valid),
		.prog_cmd(prog_cmd), .prog_sel(prog_sel), .prog_cal(prog_cal),
		.prog_wdata(prog_wdata), .prog_ack(prog_ack), .prog_refused(prog_refused),
		.prog_rdata(prog_rdata), .prog_busy(prog_busy), .flash_erase_req(flash_erase_req),
		.flash_erase_done(flash_erase_done), .eeprom_erase(eeprom_erase),
		.spm_req(spm_req), .spm_addr(spm_addr), .lpm_addr(lpm_addr),
		.pc_in_boot(pc_in_boot), .vectors_in_boot(vectors_in_boot),
		.spm_allow(spm_allow), .lpm_allow(lpm_allow), .irq_block(irq_block),
		.fuse_high_cfg(fuse_high_cfg), .fuse_low_cfg(fuse_low_cfg), .lock_cfg(lock_cfg),
		.eeprom_preserve(eeprom_preserve), .osc_calibration(osc_calibration)
	);
	lfc_flash_model fm (
		.clk(clk), .srst(srst), .slow(slow), .flash_erase_req(flash_erase_req),
		.flash_erase_done(flash_erase_done)
	);
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [31:0] ex, input logic ex_err);
		int i;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge clk) penable <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		`CHK({pready, pslverr}, {1'b1, ex_err})
		if (!w) `CHK(prdata, ex)
		psel <= 0; penable <= 0;
		@(posedge clk);
	endtask
	task automatic prog(input logic [7:0] c, input logic [1:0] s, input logic cl,
		input logic [7:0] wd, input logic ex_ref, input logic [7:0] ex_rd);
		int i;
		prog_cmd_valid <= 1; prog_cmd <= c; prog_sel <= s; prog_cal <= cl; prog_wdata <= wd;
		@(posedge clk) prog_cmd_valid <= 0;
		for (i = 0; i < 3000 && prog_ack !== 1'b1 && prog_refused !== 1'b1; i++)
			@(negedge clk);
		`CHK({prog_ack, prog_refused}, {~ex_ref, ex_ref})
		if (!ex_ref) `CHK(prog_rdata, ex_rd)
		@(posedge clk);
	endtask
	task automatic erase(input logic slw, input int ee);
		slow <= slw;
		prog(8'h80, 0, 0, 0, 0, 0);
		`CHK(prog_busy, 1'b0)
		apb(0, 12'h00c, 0, 32'h2, 0);
		lk = 8'hff;
		`CHK(lock_cfg, lk)
		`CHK(ee_n, ee)
		$display("test erase done");
	endtask
	// lock bits must not come back before the flash wipe has finished
	always @(negedge clk) if (prog_busy === 1'b1) `CHK(lock_cfg, lk)
	always @(posedge clk) if (eeprom_erase === 1'b1) ee_n++;
	initial
	begin
		#(20000 * 100);
		bad_count++;
		tally_and_finish;
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, prog_mode, prog_serial, prog_cmd_valid} = 0;
		{prog_cmd, prog_sel, prog_cal, prog_wdata, spm_req, spm_addr, lpm_addr} = 0;
		{pc_in_boot, vectors_in_boot, slow} = 0;
		srst = 1; seed = 69; lk = 8'hff;
		repeat (10) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		`CHK({lock_cfg, fuse_high_cfg, fuse_low_cfg}, 24'hffd9e1)
		`CHK({osc_calibration, eeprom_preserve}, 9'h0d8)
		apb(0, 12'h000, 0, 32'hff, 0);
		apb(0, 12'h004, 0, 32'hd9e1, 0);
		apb(0, 12'h01c, 0, 32'h83, 0);
		apb(0, 12'h040, 0, 0, 1);
		d = $random(seed);
		apb(1, 12'h008, {24'h0, d}, 0, 0);
		apb(0, 12'h008, 0, {24'h0, d}, 0);
		apb(1, 12'h004, 32'h0, 0, 0);
		apb(0, 12'h004, 0, 32'hd9e1, 0);
		$display("test register bus done");
		prog_mode <= 1;
		repeat (2) @(posedge clk);
		erase(0, 1);
		// fuses written before any lock bit, as a careful programmer does
		prog(8'h40, 1, 0, 8'hd1, 0, 0);
		`CHK({fuse_high_cfg, eeprom_preserve}, 9'h1b3)
		prog_serial <= 1;
		prog(8'h04, 1, 0, 0, 0, 8'hf1);
		prog(8'h40, 1, 0, 8'h71, 0, 0);
		prog(8'h04, 1, 0, 0, 1, 0);
		prog_serial <= 0;
		prog(8'h04, 1, 0, 0, 0, 8'h51);
		prog(8'h40, 1, 0, 8'hf1, 0, 0);
		prog_serial <= 1;
		prog(8'h04, 0, 0, 0, 1, 0);
		prog(8'h08, 0, 0, 0, 0, sig_e[0]);
		prog_serial <= 0;
		prog(8'h40, 1, 0, 8'hd1, 0, 0);
		prog_mode <= 0;
		repeat (2) @(posedge clk);
		`CHK(fuse_high_cfg, 8'hd1)
		prog_mode <= 1;
		$display("test fuses done");
		d = $random(seed) | 8'h03;
		prog(8'h20, 2, 0, d, 0, 0);
		lk = lk & (d | 8'hc0);
		`CHK(lock_cfg, lk)
		// high fuse d1 selects boot size code 00
		st = bs_e[0];
		for (k = 0; k < 24; k++)
		begin
			sa = $random(seed); la = $random(seed); r = $random(seed);
			spm_req <= 1; spm_addr <= sa; lpm_addr <= la; {pc_in_boot, vectors_in_boot} <= r[1:0];
			@(posedge clk);
			@(negedge clk);
			`CHK(spm_allow, (sa >= st) ? lk[4] : lk[2])
			`CHK(lpm_allow, (r[1] && la < st) ? lk[3] : (!r[1] && la >= st) ? lk[5] : 1'b1)
			`CHK(irq_block, (r[0] && !r[1] && !lk[3]) || (!r[0] && r[1] && !lk[5]))
			@(posedge clk);
		end
		$display("test core access done");
		prog(8'h20, 2, 0, 8'hff, 0, 0);
		`CHK(lock_cfg, lk)
		prog(8'h20, 2, 0, 8'hfe, 0, 0);
		lk = lk & 8'hfe;
		prog(8'h40, 1, 0, 8'hd9, 1, 0);
		prog(8'h10, 0, 0, 8'h00, 1, 0);
		prog(8'h20, 2, 0, 8'hfc, 0, 0);
		lk = lk & 8'hfc;
		prog(8'h02, 0, 0, 0, 1, 0);
		prog(8'h03, 0, 0, 0, 1, 0);
		for (k = 0; k < 8; k++)
			prog(8'h08, k[1:0], k[2], 0, 0, k[2] ? cal_e[k[1:0]] : sig_e[k[1:0]]);
		$display("test locked device done");
		erase(1, 1);
		`CHK(fuse_high_cfg, 8'hd1)
		tally_and_finish;
	end
endmodule
`default_nettype wire
